// File: logic/bcs_pkg.sv
// Shared constants, types and states of the bus cycle sequencer.
package bcs_pkg;

	// Address offsets relative to the instruction address.
	localparam logic [31:0] FETCH_OFS = 32'h0000_0008;
	localparam logic [31:0] IDLE_OFS  = 32'h0000_000C;
	localparam logic [31:0] WORD_STEP = 32'h0000_0004;

	// Register indices and field widths.
	localparam logic [3:0] LINK_IDX = 4'hE;
	localparam logic [3:0] PC_IDX   = 4'hF;
	localparam int         SHIFT_W  = 8;

	// Instruction classes handled by the sequencer.
	typedef enum logic [1:0] {
		OP_BRANCH,
		OP_DATA,
		OP_MUL,
		OP_LOAD
	} bcs_op_e;

	// Sequencer states, one per bus cycle of each sequence; ST_MULN covers every later multiply cycle.
	typedef enum logic [4:0] {
		ST_IDLE,
		ST_BR1, ST_BR2, ST_BR3,
		ST_DP1, ST_SH1, ST_SH2,
		ST_RF1, ST_RF2,
		ST_MUL1, ST_MULN,
		ST_LD1, ST_LD2, ST_LD3, ST_LD4, ST_LD5
	} bcs_state_e;

	// Decoded instruction as handed over by the decoder.
	typedef struct packed {
		bcs_op_e    op;
		logic       link;
		logic       reg_shift;
		logic       dest_pc;
		logic       compare;
		logic       psr_xfer;
		logic       set_flags;
		logic       accumulate;
		logic       byte_xfer;
		logic       base_wb;
		logic [3:0] dest_idx;
		logic [3:0] base_idx;
	} bcs_instr_s;

	// Memory bus indicators of one cycle.
	typedef struct packed {
		logic [31:0] addr;
		logic        byte_word_select_n;
		logic        read_write_n;
		logic        opcode_fetch_n;
		logic        memory_request_n;
		logic        sequential_cycle;
	} bcs_bus_s;

	// One register file write.
	typedef struct packed {
		logic        en;
		logic [3:0]  idx;
		logic [31:0] data;
	} bcs_wr_s;

endpackage

// File: logic/bcs_booth.sv
// Two-bit Booth multiplier with early termination.
module bcs_booth import bcs_pkg::*; #(
	parameter int W = 32
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst,
	// Control
	input  wire logic         load,
	input  wire logic         step,
	// Operands
	input  wire logic [W-1:0] init,
	input  wire logic [W-1:0] multiplier,
	input  wire logic [W-1:0] multiplicand,
	// Results
	output logic      [W-1:0] product,
	output logic              last
);

	typedef struct packed {
		logic [W-1:0] mult;
		logic         carry;
		logic [W-1:0] acc;
		logic [5:0]   n;
	} bcs_booth_s;

	bcs_booth_s r_r;
	bcs_booth_s r_nxt;
	logic [W-1:0] mc;

	// Recode two multiplier bits plus the pending borrow into one digit.
	always_comb begin
		r_nxt = r_r;
		mc = W'(multiplicand << {r_r.n, 1'b0});
		product = r_r.acc;
		unique case ({r_r.mult[1:0], r_r.carry})
			3'b001, 3'b010: product = r_r.acc + mc;
			3'b011:         product = r_r.acc + W'(mc << 1);
			3'b100:         product = r_r.acc - W'(mc << 1);
			3'b101, 3'b110: product = r_r.acc - mc;
			default:        product = r_r.acc;
		endcase
		// Nothing left after this step once the upper bits are clear.
		last = (r_r.mult[W-1:1] == '0);
		if (load) begin
			r_nxt.mult  = multiplier;
			r_nxt.carry = 1'b0;
			r_nxt.acc   = init;
			r_nxt.n     = '0;
		end else if (step) begin
			r_nxt.acc   = product;
			r_nxt.mult  = r_r.mult >> 2;
			r_nxt.carry = r_r.mult[1];
			r_nxt.n     = r_r.n + 6'h01;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			r_r <= '0;
		end else begin
			r_r <= r_nxt;
		end
	end

endmodule // bcs_booth

// File: logic/bcs_bus_map.sv
// Maps the sequencer state onto the memory bus indicators.
module bcs_bus_map import bcs_pkg::*; (
	// Sequencer state
	input  wire bcs_state_e st,
	input  wire logic       refill,
	input  wire logic       mul_last,
	input  wire logic       byte_xfer,
	// Address sources
	input  wire logic [31:0] pc,
	input  wire logic [31:0] tgt,
	input  wire logic [31:0] ldv,
	// Memory bus
	output bcs_bus_s         bus
);

	// Request and sequential bits describe the next cycle; the rest this one.
	always_comb begin
		bus = '{addr: pc + IDLE_OFS, byte_word_select_n: 1'b1,
			read_write_n: 1'b0, opcode_fetch_n: 1'b1,
			memory_request_n: 1'b1, sequential_cycle: 1'b0};
		unique case (st)
			ST_IDLE: ;
			ST_BR1, ST_DP1, ST_SH1, ST_MUL1, ST_LD1: begin
				bus.addr = pc + FETCH_OFS;
				bus.opcode_fetch_n = 1'b0;
				bus.memory_request_n = (st == ST_SH1) || (st == ST_MUL1);
				bus.sequential_cycle = (st == ST_DP1) && !refill;
			end
			ST_BR2, ST_BR3, ST_RF1, ST_RF2: begin
				bus.addr = (st == ST_BR2 || st == ST_RF1) ?
					tgt : tgt + WORD_STEP;
				bus.opcode_fetch_n = 1'b0;
				bus.memory_request_n = 1'b0;
				bus.sequential_cycle = 1'b1;
			end
			ST_SH2, ST_LD3: begin
				// Address held at pc+12 so memory may merge with the next fetch.
				bus.memory_request_n = 1'b0;
				bus.sequential_cycle = !refill;
			end
			ST_MULN: begin
				bus.memory_request_n = !mul_last;
				bus.sequential_cycle = mul_last;
			end
			ST_LD2: begin
				bus.addr = tgt;
				bus.byte_word_select_n = !byte_xfer;
			end
			ST_LD4, ST_LD5: begin
				bus.addr = (st == ST_LD4) ? ldv : ldv + WORD_STEP;
				bus.opcode_fetch_n = 1'b0;
				bus.memory_request_n = 1'b0;
				bus.sequential_cycle = 1'b1;
			end
		endcase
	end

endmodule // bcs_bus_map

// File: logic/bcs_sequencer.sv
// Per-instruction bus cycle sequencer of the core: top module.
//
// Operation
// - Request and sequential bits announce next cycle; others describe this one.
// - Branch cycle one computes target, prefetches pc+8, announces nonsequential.
// - Branch cycle two fetches target; linked branch writes return address.
// - Branch cycle three fetches target+4 sequentially; link register minus 4.
// - Plain data operation takes one cycle, prefetching pc+8, sequential next.
// - Register shift adds a cycle latching low 8 bits; operation cycle internal.
// - Internal cycle before sequential access holds address at pc+12.
// - PC write flushes pipeline, refills from alu and alu+4, blocks exceptions.
// - Compare and test update flags only, no register write.
// - Status transfers time like data operations, never using the PC.
// - Multiply uses 2-bit Booth with early stop; first cycle loads multiplier.
// - First multiply cycle initialises destination with accumulator or zero.
// - Each cycle adds, subtracts or passes shifted multiplicand until done.
// - Later multiply cycles internal; sequential request only in the last.
// - Load cycle two reads data at byte or word size, updates base.
// - Load cycle three writes destination internally, address held at pc+12.
// - Load into PC takes five cycles, fetching pc' and pc'+4.
// - Aborted load data fetch suppresses the destination register write.
module bcs_sequencer import bcs_pkg::*; (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst,
	// Instruction issue
	input  wire logic         instr_valid,
	input  wire bcs_instr_s   instr,
	input  wire logic [31:0]  instr_pc,
	output logic              instr_ready,
	output logic              instr_done,
	// Datapath operands
	input  wire logic [31:0]  alu_result,
	input  wire logic [31:0]  shift_or_multiplier_operand,
	input  wire logic [31:0]  multiplicand_operand,
	input  wire logic [31:0]  accumulate_operand,
	input  wire logic [31:0]  read_data,
	input  wire logic         data_abort,
	// Memory bus
	output bcs_bus_s          mem_bus,
	// Datapath control
	output bcs_wr_s           reg_wr,
	output logic              flags_update,
	output logic [SHIFT_W-1:0] shift_amount,
	output logic              pipeline_flush,
	output logic              exception_block
);

	typedef struct packed {
		bcs_state_e   st;
		bcs_instr_s   ins;
		logic [31:0]  pc;
		logic [31:0]  tgt;
		logic [31:0]  ldv;
		logic [SHIFT_W-1:0] shamt;
		logic         refill;
		logic         aborted;
	} bcs_seq_s;

	bcs_seq_s    r_r;
	bcs_seq_s    r_nxt;
	logic        fin;
	logic        mul_load;
	logic        mul_step;
	logic        mul_last;
	logic [31:0] mul_product;
	logic [31:0] mul_init;

	// Zero for a plain multiply, the accumulator for multiply-accumulate.
	assign mul_init = r_r.ins.accumulate ? accumulate_operand : '0;

	bcs_booth #(
		.W (32)
	) u_booth (
		.clk_sys      (clk_sys),
		.rst          (rst),
		.load         (mul_load),
		.step         (mul_step),
		.init         (mul_init),
		.multiplier   (shift_or_multiplier_operand),
		.multiplicand (multiplicand_operand),
		.product      (mul_product),
		.last         (mul_last)
	);

	bcs_bus_map u_bus_map (
		.st        (r_r.st),
		.refill    (r_r.refill && !r_r.aborted),
		.mul_last  (mul_last),
		.byte_xfer (r_r.ins.byte_xfer),
		.pc        (r_r.pc),
		.tgt       (r_r.tgt),
		.ldv       (r_r.ldv),
		.bus       (mem_bus)
	);

	// Side outputs that follow the registered state directly.
	assign shift_amount    = r_r.shamt;
	assign exception_block = (r_r.st == ST_RF1) || (r_r.st == ST_RF2) ||
		(r_r.st == ST_LD4) || (r_r.st == ST_LD5);

	// Next-state logic; a new instruction is taken in the last cycle of the
	// previous one so that sequences run back to back.
	always_comb begin
		r_nxt          = r_r;
		fin            = 1'b0;
		mul_load       = 1'b0;
		mul_step       = 1'b0;
		reg_wr         = '0;
		flags_update   = 1'b0;
		pipeline_flush = 1'b0;
		unique case (r_r.st)
			ST_IDLE: fin = 1'b1;
			ST_BR1: begin
				r_nxt.tgt = alu_result;
				pipeline_flush = 1'b1;
				r_nxt.st = ST_BR2;
			end
			ST_BR2: begin
				reg_wr = '{en: r_r.ins.link, idx: LINK_IDX,
					data: r_r.pc + FETCH_OFS};
				r_nxt.st = ST_BR3;
			end
			ST_BR3: begin
				reg_wr = '{en: r_r.ins.link, idx: LINK_IDX,
					data: r_r.pc + FETCH_OFS - WORD_STEP};
				fin = 1'b1;
			end
			ST_SH1: begin
				r_nxt.shamt = shift_or_multiplier_operand[SHIFT_W-1:0];
				r_nxt.st = ST_SH2;
			end
			ST_DP1, ST_SH2: begin
				// Compares and tests leave every register untouched.
				flags_update = r_r.ins.compare || r_r.ins.set_flags;
				reg_wr = '{en: !r_r.ins.compare,
					idx: r_r.refill ? PC_IDX : r_r.ins.dest_idx,
					data: alu_result};
				if (r_r.refill) begin
					r_nxt.tgt = alu_result;
					pipeline_flush = 1'b1;
					r_nxt.st = ST_RF1;
				end else begin
					fin = 1'b1;
				end
			end
			ST_RF1: r_nxt.st = ST_RF2;
			ST_RF2: fin = 1'b1;
			ST_MUL1: begin
				mul_load = 1'b1;
				reg_wr = '{en: 1'b1, idx: r_r.ins.dest_idx,
					data: mul_init};
				r_nxt.st = ST_MULN;
			end
			ST_MULN: begin
				mul_step = 1'b1;
				if (mul_last) begin
					reg_wr = '{en: 1'b1, idx: r_r.ins.dest_idx,
						data: mul_product};
					fin = 1'b1;
				end
			end
			ST_LD1: begin
				r_nxt.tgt = alu_result;
				r_nxt.st = ST_LD2;
			end
			ST_LD2: begin
				r_nxt.ldv = read_data;
				r_nxt.aborted = data_abort;
				reg_wr = '{en: r_r.ins.base_wb, idx: r_r.ins.base_idx,
					data: alu_result};
				r_nxt.st = ST_LD3;
			end
			ST_LD3: begin
				// The loaded value lands here; an aborted fetch writes nothing.
				reg_wr = '{en: !r_r.aborted,
					idx: r_r.refill ? PC_IDX : r_r.ins.dest_idx,
					data: r_r.ldv};
				if (r_r.refill && !r_r.aborted) begin
					pipeline_flush = 1'b1;
					r_nxt.st = ST_LD4;
				end else begin
					fin = 1'b1;
				end
			end
			ST_LD4: r_nxt.st = ST_LD5;
			ST_LD5: fin = 1'b1;
		endcase
		instr_ready = fin;
		instr_done  = fin && (r_r.st != ST_IDLE);
		if (fin) begin
			r_nxt.st = ST_IDLE;
			if (instr_valid) begin
				r_nxt.ins     = instr;
				r_nxt.pc      = instr_pc;
				r_nxt.aborted = 1'b0;
				// Status transfers never target the PC.
				r_nxt.refill  = instr.dest_pc && !instr.compare &&
					!instr.psr_xfer;
				unique case (instr.op)
					OP_BRANCH: r_nxt.st = ST_BR1;
					OP_DATA:   r_nxt.st = instr.reg_shift ? ST_SH1 : ST_DP1;
					OP_MUL:    r_nxt.st = ST_MUL1;
					OP_LOAD:   r_nxt.st = ST_LD1;
				endcase
			end
		end
	end

	// All sequencer state in one register.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			r_r <= '0;
		end else begin
			r_r <= r_nxt;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// An idle request is followed by a cycle that fetches no instruction.
	chk_req_ahead: assert property (
		(r_r.st != ST_IDLE && mem_bus.memory_request_n && !instr_done)
		|=> mem_bus.opcode_fetch_n)
		else $error("fetch followed an announced idle cycle");

	chk_branch_first: assert property (
		r_r.st == ST_BR1 |-> mem_bus.addr == r_r.pc + FETCH_OFS &&
		!mem_bus.memory_request_n && !mem_bus.sequential_cycle)
		else $error("branch first cycle bus wrong");

	chk_branch_target: assert property (
		r_r.st == ST_BR1 |=> mem_bus.addr == $past(alu_result) &&
		!mem_bus.opcode_fetch_n ##1 mem_bus.sequential_cycle)
		else $error("branch target fetch wrong");

	chk_link_adjust: assert property (
		(r_r.st == ST_BR2 && r_r.ins.link) |=> reg_wr.en &&
		reg_wr.data == $past(reg_wr.data) - WORD_STEP)
		else $error("link register not reduced by one word");

	chk_dp_single: assert property (
		(r_r.st == ST_DP1 && !r_r.refill) |-> instr_ready &&
		mem_bus.sequential_cycle && !mem_bus.opcode_fetch_n)
		else $error("plain data operation not single cycle");

	chk_shift_latch: assert property (
		r_r.st == ST_SH1 |=> shift_amount ==
		$past(shift_or_multiplier_operand[SHIFT_W-1:0]) &&
		mem_bus.opcode_fetch_n)
		else $error("shift amount not latched");

	chk_idle_addr: assert property (
		(r_r.st == ST_SH2 || r_r.st == ST_LD3 || r_r.st == ST_MULN)
		|-> mem_bus.addr == r_r.pc + IDLE_OFS)
		else $error("internal cycle address not held");

	chk_refill_block: assert property (
		r_r.st == ST_RF1 |-> exception_block ##1
		(exception_block && mem_bus.addr == r_r.tgt + WORD_STEP))
		else $error("refill not protected");

	chk_cmp_nowrite: assert property (
		((r_r.st == ST_DP1 || r_r.st == ST_SH2) && r_r.ins.compare)
		|-> !reg_wr.en && flags_update)
		else $error("compare wrote a register");

	chk_mul_internal: assert property (
		(r_r.st == ST_MULN && !mul_last) |-> mem_bus.memory_request_n
		##1 r_r.st == ST_MULN)
		else $error("multiply cycle not internal");

	chk_load_abort: assert property (
		(r_r.st == ST_LD2 && data_abort) |=> !reg_wr.en && instr_ready)
		else $error("aborted load wrote a register");

	// Idle cycles announce no access and close no sequence.
	chk_idle_quiet: assert property (
		r_r.st == ST_IDLE |-> mem_bus.memory_request_n &&
		!mem_bus.sequential_cycle && !instr_done)
		else $error("idle cycle announced a memory access");

	// The link write is offered only when the instruction asks for it.
	chk_link_write: assert property (
		r_r.st == ST_BR2 |-> reg_wr.en == r_r.ins.link &&
		reg_wr.idx == LINK_IDX)
		else $error("link register write wrong");

	// A PC write flushes, announces a jump and starts the refill.
	chk_dp_refill: assert property (
		((r_r.st == ST_DP1 || r_r.st == ST_SH2) && r_r.refill) |->
		pipeline_flush && !mem_bus.sequential_cycle && reg_wr.en &&
		reg_wr.idx == PC_IDX ##1 r_r.st == ST_RF1)
		else $error("data operation into PC did not refill");

	// A status transfer must never start a refill, whatever it names.
	chk_psr_timing: assert property (
		((r_r.st == ST_DP1 || r_r.st == ST_SH2) && r_r.ins.psr_xfer) |->
		instr_ready && !pipeline_flush && mem_bus.sequential_cycle)
		else $error("status transfer touched the PC");

	// The Booth shifter holds the multiplier one cycle after the load.
	chk_mul_load: assert property (
		r_r.st == ST_MUL1 |=> r_r.st == ST_MULN && mul_last ==
		($past(shift_or_multiplier_operand[31:1]) == '0))
		else $error("multiplier not loaded into the shifter");

	chk_mul_init: assert property (
		r_r.st == ST_MUL1 |-> reg_wr.en &&
		reg_wr.idx == r_r.ins.dest_idx &&
		reg_wr.data == (r_r.ins.accumulate ? accumulate_operand : '0))
		else $error("multiply destination not initialised");

	// Early termination: at most 16 digit pairs plus one borrow cycle.
	chk_mul_bound: assert property (
		r_r.st == ST_MUL1 |-> ##[1:17] (r_r.st == ST_MULN && mul_last))
		else $error("multiply did not terminate");

	chk_mul_final: assert property (
		(r_r.st == ST_MULN && mul_last) |-> !mem_bus.memory_request_n &&
		mem_bus.sequential_cycle && instr_done && reg_wr.en)
		else $error("multiply last cycle wrong");

	chk_load_fetch: assert property (
		r_r.st == ST_LD1 |=> mem_bus.addr == $past(alu_result) &&
		mem_bus.byte_word_select_n == !r_r.ins.byte_xfer &&
		mem_bus.opcode_fetch_n && reg_wr.en == r_r.ins.base_wb)
		else $error("load data fetch wrong");

	// The write-back cycle stays off the bus and uses the fetched word.
	chk_load_internal: assert property (
		r_r.st == ST_LD2 |-> mem_bus.memory_request_n ##1
		(mem_bus.opcode_fetch_n && reg_wr.data == $past(read_data)))
		else $error("load write-back cycle wrong");

	chk_pc_load: assert property (
		(r_r.st == ST_LD3 && r_r.refill && !r_r.aborted) |->
		pipeline_flush && !mem_bus.sequential_cycle ##1
		(mem_bus.addr == r_r.ldv && !mem_bus.opcode_fetch_n) ##1
		(mem_bus.addr == r_r.ldv + WORD_STEP && instr_done))
		else $error("load into PC did not refill");

	// Only fetch states drive the opcode indicator low; no cycle writes.
	chk_opc_read: assert property (
		!mem_bus.read_write_n && (mem_bus.opcode_fetch_n == (r_r.st inside
		{ST_IDLE, ST_SH2, ST_MULN, ST_LD2, ST_LD3})))
		else $error("opcode or direction indicator wrong");

endmodule // bcs_sequencer

// File: bench/bcs_mem_model.sv
// Behavioural model of the external memory system seen by the sequencer.
module bcs_mem_model import bcs_pkg::*; #(
	parameter logic [31:0] ABORT_ADDR = 32'h0000_0F00,
	parameter logic [31:0] DATA_KEY   = 32'h5A5A_0000
) (
	// Clock and reset
	input  wire logic     clk_sys,
	input  wire logic     rst,
	// Memory bus
	input  wire bcs_bus_s mem_bus,
	output logic [31:0]   read_data,
	output logic          data_abort
);
	timeunit 1ns;
	timeprecision 1ps;

	logic        mem_cyc_r;
	logic [31:0] last_r;

	// A request announced in one cycle makes the following cycle a memory
	// cycle, so the announcement is registered here.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mem_cyc_r <= 1'b0;
			last_r    <= 32'h0000_0000;
		end else begin
			mem_cyc_r <= ~mem_bus.memory_request_n;
			last_r    <= read_data;
		end
	end

	// Outside memory cycles the bus shows the inverse of its last value, so
	// a sequencer that samples a stale bus cannot pass by luck.
	always_comb begin
		read_data  = mem_cyc_r ? (mem_bus.addr ^ DATA_KEY) : ~last_r;
		data_abort = mem_cyc_r && (mem_bus.addr == ABORT_ADDR);
	end
endmodule // bcs_mem_model

// File: bench/tb_top.sv
// Self-checking testbench of the bus cycle sequencer.
module tb_top import bcs_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_sys, rst, instr_valid, instr_ready, instr_done;
	bcs_instr_s  instr;
	logic [31:0] instr_pc, alu_result, shift_or_multiplier_operand;
	logic [31:0] multiplicand_operand, accumulate_operand, read_data;
	logic        data_abort, flags_update, pipeline_flush, exception_block;
	bcs_bus_s    mem_bus;
	bcs_wr_s     reg_wr;
	logic [SHIFT_W-1:0] shift_amount;
	int          mismatches, cmp_count;

	bcs_sequencer u_dut (.clk_sys(clk_sys), .rst(rst),
		.instr_valid(instr_valid), .instr(instr), .instr_pc(instr_pc),
		.instr_ready(instr_ready), .instr_done(instr_done),
		.alu_result(alu_result),
		.shift_or_multiplier_operand(shift_or_multiplier_operand),
		.multiplicand_operand(multiplicand_operand),
		.accumulate_operand(accumulate_operand), .read_data(read_data),
		.data_abort(data_abort), .mem_bus(mem_bus), .reg_wr(reg_wr),
		.flags_update(flags_update), .shift_amount(shift_amount),
		.pipeline_flush(pipeline_flush),
		.exception_block(exception_block));

	bcs_mem_model u_mem (.clk_sys(clk_sys), .rst(rst), .mem_bus(mem_bus),
		.read_data(read_data), .data_abort(data_abort));

	// Clock at 40 MHz.
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// Counts one comparison and reports a mismatch at once.
	task automatic chk(input logic [63:0] exp, input logic [63:0] act);
		cmp_count++;
		if (act !== exp) begin
			mismatches++;
			$display("ERROR t=%0t exp=%h act=%h", $time, exp, act);
		end
	endtask

	// Compares one flag.
	task automatic flag(input logic exp, input logic act);
		chk(64'(exp), 64'(act));
	endtask

	// Compares the bus of this cycle; every cycle here is a read.
	task automatic chk_bus(input logic [31:0] a, input logic bw, opc, mrq,
		input logic sq);
		bcs_bus_s e;
		e = '{a, bw, 1'b0, opc, mrq, sq};
		chk(64'(e), 64'(mem_bus));
	endtask

	// Compares the register write; data matters only when it is enabled.
	task automatic chk_wr(input logic en, input logic [3:0] idx,
		input logic [31:0] d);
		if (en)
			chk(64'({en, idx, d}), 64'(reg_wr));
		else
			flag(1'b0, reg_wr.en);
	endtask

	// Moves to the next cycle, just after the edge.
	task automatic step();
		@(posedge clk_sys);
		#2;
	endtask

	// Offers one instruction; returns in its first cycle. Valid stays up
	// until the next offer, since it is ignored while ready is low; the
	// main sequence lowers it during any last cycle that has no successor.
	task automatic issue(input bcs_instr_s i, input logic [31:0] pc);
		instr       = i;
		instr_pc    = pc;
		instr_valid = 1'b1;
		flag(1'b1, instr_ready);
		step();
	endtask

	// Linked branch: prefetch, target fetch, target+4, link fixed up.
	task automatic t_branch();
		bcs_instr_s i;
		i = '0;
		i.op = OP_BRANCH;
		i.link = 1'b1;
		alu_result = 32'h0000_2000;
		issue(i, 32'h0000_0100);
		chk_bus(32'h0000_0108, 1'b1, 1'b0, 1'b0, 1'b0);
		flag(1'b1, pipeline_flush);
		step();
		chk_bus(32'h0000_2000, 1'b1, 1'b0, 1'b0, 1'b1);
		chk_wr(1'b1, LINK_IDX, 32'h0000_0108);
		step();
		chk_bus(32'h0000_2004, 1'b1, 1'b0, 1'b0, 1'b1);
		chk_wr(1'b1, LINK_IDX, 32'h0000_0104);
		flag(1'b1, instr_done);
	endtask

	// Single-cycle data operations: plain, compare, status transfer to PC.
	task automatic t_data();
		bcs_instr_s i;
		for (int k = 0; k < 3; k++) begin
			i = '0;
			i.op = OP_DATA;
			i.dest_idx = 4'h3;
			i.compare = (k == 1);
			i.psr_xfer = (k == 2);
			i.dest_pc = (k == 2);
			alu_result = 32'h0000_1230 + 32'(k);
			issue(i, 32'h0000_0200);
			chk_bus(32'h0000_0208, 1'b1, 1'b0, 1'b0, 1'b1);
			flag(1'b1, instr_done);
			flag(1'b0, pipeline_flush);
			if (k == 0)
				chk_wr(1'b1, 4'h3, 32'h0000_1230);
			if (k == 1) begin
				chk_wr(1'b0, 4'h0, 32'h0000_0000);
				flag(1'b1, flags_update);
			end
			if (k == 2)
				chk_wr(1'b1, 4'h3, 32'h0000_1232);
		end
	endtask

	// Register-specified shift: latch cycle, then an internal cycle.
	task automatic t_shift();
		bcs_instr_s i;
		i = '0;
		i.op = OP_DATA;
		i.reg_shift = 1'b1;
		i.dest_idx = 4'h5;
		alu_result = 32'h0000_4444;
		shift_or_multiplier_operand = 32'h1234_56AB;
		issue(i, 32'h0000_0300);
		chk_bus(32'h0000_0308, 1'b1, 1'b0, 1'b1, 1'b0);
		step();
		shift_or_multiplier_operand = 32'h0000_0000;
		flag(1'b1, 8'hAB === shift_amount);
		chk_bus(32'h0000_030C, 1'b1, 1'b1, 1'b0, 1'b1);
		chk_wr(1'b1, 4'h5, 32'h0000_4444);
		flag(1'b1, instr_done);
	endtask

	// Data operation into the PC: flush and refill with exceptions held.
	task automatic t_refill();
		bcs_instr_s i;
		i = '0;
		i.op = OP_DATA;
		i.dest_pc = 1'b1;
		i.dest_idx = PC_IDX;
		alu_result = 32'h0000_5000;
		issue(i, 32'h0000_0400);
		chk_bus(32'h0000_0408, 1'b1, 1'b0, 1'b0, 1'b0);
		flag(1'b1, pipeline_flush);
		chk_wr(1'b1, PC_IDX, 32'h0000_5000);
		step();
		chk_bus(32'h0000_5000, 1'b1, 1'b0, 1'b0, 1'b1);
		flag(1'b1, exception_block);
		step();
		chk_bus(32'h0000_5004, 1'b1, 1'b0, 1'b0, 1'b1);
		flag(1'b1, exception_block & instr_done);
	endtask

	// Multiply and accumulate over several multiplier values.
	task automatic t_mul();
		bcs_instr_s i;
		logic [31:0] rs [4] = '{32'h0, 32'h1, 32'h6, 32'h0001_0003};
		int m_exp [4] = '{1, 1, 2, 9};
		int n;
		for (int k = 0; k < 4; k++) begin
			i = '0;
			i.op = OP_MUL;
			i.accumulate = k[0];
			i.dest_idx = 4'h7;
			shift_or_multiplier_operand = rs[k];
			multiplicand_operand = 32'h0000_0123;
			accumulate_operand = 32'h0000_1000;
			issue(i, 32'h0000_0600);
			chk_bus(32'h0000_0608, 1'b1, 1'b0, 1'b1, 1'b0);
			chk_wr(1'b1, 4'h7, k[0] ? 32'h0000_1000 : 32'h0);
			n = 0;
			do begin
				step();
				n++;
				chk_bus(32'h0000_060C, 1'b1, 1'b1, ~instr_done, instr_done);
			end while (instr_done !== 1'b1 && n < 40);
			chk(64'(m_exp[k]), 64'(n));
			chk_wr(1'b1, 4'h7, (k[0] ? 32'h0000_1000 : 32'h0)
				+ rs[k] * 32'h0000_0123);
		end
	endtask

	// Loads: word with write-back, byte, into the PC, and an aborted one.
	task automatic t_load();
		bcs_instr_s i;
		logic [31:0] a, d;
		for (int k = 0; k < 4; k++) begin
			a = (k == 3) ? 32'h0000_0F00 : 32'h0000_1000 + 32'(k * 16);
			d = a ^ 32'h5A5A_0000;
			i = '0;
			i.op = OP_LOAD;
			i.base_wb = (k == 0);
			i.byte_xfer = (k == 1);
			i.dest_pc = (k >= 2);
			i.dest_idx = (k >= 2) ? PC_IDX : 4'h2;
			i.base_idx = 4'h9;
			alu_result = a;
			issue(i, 32'h0000_0800);
			chk_bus(32'h0000_0808, 1'b1, 1'b0, 1'b0, 1'b0);
			step();
			chk_bus(a, k != 1, 1'b1, 1'b1, 1'b0);
			chk_wr(k == 0, 4'h9, a);
			step();
			chk_bus(32'h0000_080C, 1'b1, 1'b1, 1'b0, k != 2);
			chk_wr(k != 3, i.dest_idx, d);
			flag(k == 2, pipeline_flush);
			if (k == 2) begin
				step();
				chk_bus(d, 1'b1, 1'b0, 1'b0, 1'b1);
				step();
				chk_bus(d + 32'h4, 1'b1, 1'b0, 1'b0, 1'b1);
			end
			flag(1'b1, instr_done);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Main sequence; scenarios follow each other back to back.
	initial begin
		mismatches = 0;
		cmp_count = 0;
		rst = 1'b1;
		instr_valid = 1'b0;
		instr = '0;
		instr_pc = 32'h0;
		alu_result = 32'h0;
		shift_or_multiplier_operand = 32'h0;
		multiplicand_operand = 32'h0;
		accumulate_operand = 32'h0;
		repeat (4) @(posedge clk_sys);
		#2;
		chk_bus(32'h0000_000C, 1'b1, 1'b1, 1'b1, 1'b0);
		rst = 1'b0;
		step();
		t_branch();
		t_data();
		t_shift();
		t_refill();
		t_mul();
		t_load();
		instr_valid = 1'b0;
		step();
		close_out();
	end

	// A hang is cut short well beyond the 48 cycles needed.
	initial begin
		repeat (5000) @(posedge clk_sys);
		mismatches++;
		close_out();
	end
endmodule // tb_top
